// File: adcs_pkg.sv
// constants, types and register map of the conversion sequencer
//------------------------------------------------------------------
// Functional notes
// - after the main clock starts, wait 256+44 modulator periods before filtering.
// - first two results come from the fast filter, sinc3 from the third.
// - fast path settles in one period, sinc3 in three; 3372 at OSR 1024.
// - data-ready rises low to high when the power-on interval ends.
// - every reset selects the external clock; host reselects the oscillator.
// - command or pin reset skips power-on, repeats the wait, uses fast filter.
// - continuous mode: a result every OSR periods, marked by data-ready falling.
// - chop enabled: input polarity alternates between consecutive internal conversions.
// - chop results average a sliding pair of internal conversions.
// - filter resets at every polarity swap; three conversions per chop result.
// - four-bit chop delay field selects 2 to 65536 modulator periods.
// - chop period is delay plus three OSR; each result makes data-ready fall.
// - chop mode: sync falling edge or OSR change restarts all channels.
// - first chop period after restart is two full periods plus 44.
// - dc test signal is not supported together with chop mode.
// - two-bit power mode field selects one of three levels in both modes.
// - standby disables channels, reference and oscillator, keeps registers; wakeup leaves.
// - sync edge aligned with the data clock does nothing, misaligned resets filters.
// - sync pin low beyond the threshold resets until it returns high.
// - any reset restores configuration defaults; conversions resume with a clock.
//------------------------------------------------------------------
package adcs_pkg;
	localparam int CLK_MHZ = 100;
	localparam int POR_NS = 20000;
	localparam int POR_CYC = (POR_NS * CLK_MHZ + 999) / 1000;
	localparam int RST_LOW_NS = 1000;
	localparam int RST_LOW_CYC = (RST_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int RSTW = 8;
	localparam int OSC_DIV = 12;
	localparam int WAIT_BASE = 256;
	localparam int WAIT_EXTRA = 44;
	localparam int WAIT_CYC = WAIT_BASE + WAIT_EXTRA;
	localparam int GC_FIRST_EXTRA = 44;
	localparam int GC_MULT = 3;
	localparam int FAST_SAMPLES = 2;
	localparam int OSR_MIN = 128;
	localparam int CW = 18;
	localparam logic [1:0] PIN_RST = 2'h2;
	// register byte offsets
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	// config fields
	localparam int F_OSC = 0;
	localparam int F_CHOP = 1;
	localparam int F_DLY = 2;
	localparam int F_PWR = 6;
	localparam int F_OSR = 8;
	localparam logic [3:0] DLY_RST = 4'h0;
	localparam logic [2:0] OSR_RST = 3'h3;
	// command bits
	localparam int C_RESET = 0;
	localparam int C_STBY = 1;
	localparam int C_WAKE = 2;
	// status fields
	localparam int S_DATA_READY_N = 0;
	localparam int S_STBY = 1;
	localparam int S_SWAP = 2;
	localparam int S_FAST = 3;
	localparam int S_RUN = 4;
	localparam int S_CNT = 8;
	localparam logic [1:0] high_resolution_power = 2'h0;
	localparam logic [1:0] reduced_power_level = 2'h1;
	localparam logic [1:0] minimum_power_level = 2'h2;
	typedef enum logic [2:0] {ST_POR, ST_HOLD, ST_WAIT, ST_CONV, ST_STBY} adcs_state_t;
endpackage : adcs_pkg

// File: adcs_pin_if.sv
// pin events passed from the pin conditioner to the sequencer
`timescale 1ns/1ps
interface adcs_pin_if;
	logic clk_rise;
	logic sync_fall;
	logic pin_reset;
	modport cond (output clk_rise, output sync_fall, output pin_reset);
	modport seq (input clk_rise, input sync_fall, input pin_reset);
endinterface : adcs_pin_if

// File: adcs_pin_cond.sv
// synchronisers and edge / width detection for the clock and sync pins
`timescale 1ns/1ps
module adcs_pin_cond
	import adcs_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic ext_clock_in,
	input wire logic sync_reset_n,
	adcs_pin_if.cond pins
);
	logic [1:0] raw;
	logic [RSTW-1:0] low_cnt_ff;
	logic pin_reset_ff;

	assign raw = {sync_reset_n, ext_clock_in};

	for (genvar i = 0; i < 2; i++) begin : g_pin
		logic [2:0] sh_ff;
		logic lvl_ff;
		logic prev_ff;
		logic rise;
		logic fall;
		// a change is taken only once stages two and three agree
		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				sh_ff <= {3{PIN_RST[i]}};
				lvl_ff <= PIN_RST[i];
				prev_ff <= PIN_RST[i];
			end else begin
				sh_ff <= {sh_ff[1:0], raw[i]};
				if (sh_ff[1] == sh_ff[2]) begin
					lvl_ff <= sh_ff[2];
				end
				prev_ff <= lvl_ff;
			end
		end
		assign rise = lvl_ff & ~prev_ff;
		assign fall = ~lvl_ff & prev_ff;
	end

	// low-width measure: short pulse is a sync, long one holds reset
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			low_cnt_ff <= '0;
			pin_reset_ff <= 1'b0;
		end else begin
			if (g_pin[1].lvl_ff) begin
				low_cnt_ff <= '0;
			end else if (low_cnt_ff != RSTW'(RST_LOW_CYC)) begin
				low_cnt_ff <= low_cnt_ff + RSTW'(1);
			end
			pin_reset_ff <= !g_pin[1].lvl_ff && (low_cnt_ff == RSTW'(RST_LOW_CYC));
		end
	end

	assign pins.clk_rise = g_pin[0].rise;
	assign pins.sync_fall = g_pin[1].fall;
	assign pins.pin_reset = pin_reset_ff;
endmodule : adcs_pin_cond

// File: adcs_seq_top.sv
// four-channel converter sequencer with an ahb-lite register slave
//
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
module adcs_seq_top
	import adcs_pkg::*;
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic ext_clock_in,
	input wire logic sync_reset_n,
	output logic data_ready_n,
	output logic [3:0] chan_enable,
	output logic ref_enable,
	output logic osc_enable,
	output logic input_swap,
	output logic filter_reset,
	output logic fast_filter_sel,
	output logic [1:0] power_mode_sel
);
	adcs_pin_if ifc();
	adcs_state_t state_ff;
	logic [31:0] hrdata_ff;
	logic wr_pend_ff;
	logic [7:0] wr_addr_ff;
	logic osc_sel_ff, chop_enable_ff;
	logic [3:0] chop_delay_sel_ff;
	logic [1:0] pwr_ff;
	logic [2:0] osr_sel_ff;
	logic [$clog2(POR_CYC)-1:0] por_cnt_ff;
	logic [CW-1:0] cnt_ff;
	logic first_ff;
	logic [1:0] fast_left_ff;
	logic data_ready_n_ff, swap_ff, frst_ff, ref_ff, osc_en_ff;
	logic [3:0] chan_ff;
	logic [7:0] res_cnt_ff;
	logic [3:0] osc_cnt_ff;
	logic [2:0] div_ff;

	adcs_pin_cond u_pins (
		.clock(clock),
		.rstn(rstn),
		.ext_clock_in(ext_clock_in),
		.sync_reset_n(sync_reset_n),
		.pins(ifc.cond)
	);

	//------------------------------------------------------------------
	// register slave
	//------------------------------------------------------------------
	logic ap, cfg_wr, cmd_wr, stat_rd, cmd_reset, cmd_stby, cmd_wake, soft_rst, osr_chg;
	assign ap = hsel && htrans[1] && hready;
	assign cfg_wr = wr_pend_ff && wr_addr_ff == OFS_CONFIG;
	assign cmd_wr = wr_pend_ff && wr_addr_ff == OFS_CMD;
	assign stat_rd = ap && !hwrite && haddr[7:0] == OFS_STATUS;
	assign cmd_reset = cmd_wr && hwdata[C_RESET];
	assign cmd_stby = cmd_wr && hwdata[C_STBY];
	assign cmd_wake = cmd_wr && hwdata[C_WAKE];
	assign soft_rst = cmd_reset || ifc.pin_reset;
	assign osr_chg = cfg_wr && hwdata[F_OSR+:3] != osr_sel_ff;
	// zero wait states: every transfer completes in its first data phase
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
		end else begin
			wr_pend_ff <= ap && hwrite;
			wr_addr_ff <= haddr[7:0];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hrdata_ff <= 32'h0;
		end else if (ap && !hwrite) begin
			case (haddr[7:0])
				OFS_CONFIG: begin
					hrdata_ff <= {21'h0, osr_sel_ff, pwr_ff, chop_delay_sel_ff,
						chop_enable_ff, osc_sel_ff};
				end
				OFS_STATUS: begin
					hrdata_ff <= {16'h0, res_cnt_ff, 3'h0, chan_ff[0], fast_left_ff != 2'h0,
						swap_ff, state_ff == ST_STBY, data_ready_n_ff};
				end
				default: begin
					hrdata_ff <= 32'h0;
				end
			endcase
		end
	end

	// configuration survives standby but not a reset
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			osc_sel_ff <= 1'b0;
			chop_enable_ff <= 1'b0;
			chop_delay_sel_ff <= DLY_RST;
			pwr_ff <= high_resolution_power;
			osr_sel_ff <= OSR_RST;
		end else if (soft_rst) begin
			osc_sel_ff <= 1'b0;
			chop_enable_ff <= 1'b0;
			chop_delay_sel_ff <= DLY_RST;
			pwr_ff <= high_resolution_power;
			osr_sel_ff <= OSR_RST;
		end else if (cfg_wr) begin
			osc_sel_ff <= hwdata[F_OSC];
			chop_enable_ff <= hwdata[F_CHOP];
			chop_delay_sel_ff <= hwdata[F_DLY+:4];
			pwr_ff <= hwdata[F_PWR+:2];
			osr_sel_ff <= hwdata[F_OSR+:3];
		end
	end
	assign power_mode_sel = pwr_ff;

	//------------------------------------------------------------------
	// main clock and modulator tick
	//------------------------------------------------------------------
	logic osc_tick, mclk_evt, mod_tick;
	logic [2:0] div_top;
	assign osc_tick = osc_en_ff && osc_cnt_ff == 4'(OSC_DIV - 1);
	assign mclk_evt = osc_sel_ff ? osc_tick : ifc.clk_rise;
	// modulator runs at main clock / 2, 4 or 8 by power level
	always_comb begin
		case (pwr_ff)
			reduced_power_level: div_top = 3'h3;
			minimum_power_level: div_top = 3'h7;
			default: div_top = 3'h1;
		endcase
	end
	assign mod_tick = mclk_evt && div_ff == div_top;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			osc_cnt_ff <= 4'h0;
			div_ff <= 3'h0;
		end else begin
			osc_cnt_ff <= (!osc_en_ff || osc_tick) ? 4'h0 : osc_cnt_ff + 4'h1;
			if (mod_tick) begin
				div_ff <= 3'h0;
			end else if (mclk_evt) begin
				div_ff <= div_ff + 3'h1;
			end
		end
	end

	//------------------------------------------------------------------
	// conversion timing
	//------------------------------------------------------------------
	logic [CW-1:0] osr, chop_delay_sel, gc_period, target;
	logic in_conv, at_end, restart_gc, sync_mis, result_evt, mid_swap, swap_evt, wait_done;
	assign osr = CW'(OSR_MIN) << osr_sel_ff;
	assign chop_delay_sel = CW'(1) << ({1'b0, chop_delay_sel_ff} + 5'h1);
	assign gc_period = chop_delay_sel + CW'(GC_MULT) * osr;
	always_comb begin
		if (!chop_enable_ff) begin
			target = osr;
		end else if (first_ff) begin
			target = CW'(2) * gc_period + CW'(GC_FIRST_EXTRA);
		end else begin
			target = gc_period;
		end
	end
	assign in_conv = state_ff == ST_CONV && !soft_rst && !cmd_stby;
	assign at_end = mod_tick && cnt_ff == target - CW'(1);
	assign restart_gc = in_conv && chop_enable_ff && (ifc.sync_fall || osr_chg);
	// sync edge counts as aligned when it lands on the period boundary
	assign sync_mis = in_conv && !chop_enable_ff && ifc.sync_fall && cnt_ff != '0;
	assign result_evt = in_conv && at_end && !restart_gc && !sync_mis;
	assign mid_swap = in_conv && chop_enable_ff && first_ff && !restart_gc
		&& mod_tick && cnt_ff == gc_period - CW'(1);
	assign swap_evt = chop_enable_ff && (result_evt || mid_swap);
	assign wait_done = state_ff == ST_WAIT && !soft_rst && !cmd_stby && mod_tick
		&& cnt_ff == CW'(WAIT_CYC - 1);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ST_POR;
			por_cnt_ff <= '0;
			cnt_ff <= '0;
			first_ff <= 1'b1;
		end else if (soft_rst) begin
			state_ff <= ifc.pin_reset ? ST_HOLD : ST_WAIT;
			cnt_ff <= '0;
		end else if (cmd_stby && (state_ff == ST_WAIT || state_ff == ST_CONV)) begin
			state_ff <= ST_STBY;
		end else begin
			case (state_ff)
				ST_POR: begin
					por_cnt_ff <= por_cnt_ff + $bits(por_cnt_ff)'(1);
					if (por_cnt_ff == $bits(por_cnt_ff)'(POR_CYC - 1)) begin
						state_ff <= ST_WAIT;
						cnt_ff <= '0;
					end
				end
				ST_HOLD: begin
					state_ff <= ST_WAIT;
					cnt_ff <= '0;
				end
				ST_WAIT: begin
					if (wait_done) begin
						state_ff <= ST_CONV;
						cnt_ff <= '0;
						first_ff <= 1'b1;
					end else if (mod_tick) begin
						cnt_ff <= cnt_ff + CW'(1);
					end
				end
				ST_CONV: begin
					if (restart_gc || sync_mis) begin
						cnt_ff <= '0;
						first_ff <= 1'b1;
					end else if (at_end) begin
						cnt_ff <= '0;
						first_ff <= 1'b0;
					end else if (mod_tick) begin
						cnt_ff <= cnt_ff + CW'(1);
					end
				end
				ST_STBY: begin
					if (cmd_wake) begin
						state_ff <= ST_WAIT;
						cnt_ff <= '0;
					end
				end
				default: begin
					state_ff <= ST_WAIT;
				end
			endcase
		end
	end

	// first results come from the fast path, later ones from sinc3
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fast_left_ff <= 2'(FAST_SAMPLES);
			res_cnt_ff <= 8'h00;
		end else if (soft_rst) begin
			fast_left_ff <= 2'(FAST_SAMPLES);
			res_cnt_ff <= 8'h00;
		end else begin
			if (wait_done) begin
				fast_left_ff <= 2'(FAST_SAMPLES);
			end else if (result_evt && fast_left_ff != 2'h0) begin
				fast_left_ff <= fast_left_ff - 2'h1;
			end
			if (result_evt) begin
				res_cnt_ff <= res_cnt_ff + 8'h01;
			end
		end
	end
	assign fast_filter_sel = fast_left_ff != 2'h0;

	// filter restarts on every swap; the dc test path is not offered here
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			swap_ff <= 1'b0;
			frst_ff <= 1'b1;
		end else begin
			frst_ff <= soft_rst || wait_done || swap_evt || restart_gc || sync_mis;
			if (soft_rst || wait_done || restart_gc) begin
				swap_ff <= 1'b0;
			end else if (swap_evt) begin
				swap_ff <= !swap_ff;
			end
		end
	end
	assign input_swap = swap_ff;
	assign filter_reset = frst_ff;

	// data-ready: low marks new data, status read releases it
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			data_ready_n_ff <= 1'b0;
		end else if (soft_rst) begin
			data_ready_n_ff <= 1'b0;
		end else begin
			case (state_ff)
				ST_POR: begin
					data_ready_n_ff <= por_cnt_ff == $bits(por_cnt_ff)'(POR_CYC - 1);
				end
				ST_HOLD, ST_WAIT, ST_STBY: begin
					data_ready_n_ff <= 1'b1;
				end
				ST_CONV: begin
					if (result_evt) begin
						data_ready_n_ff <= 1'b0;
					end else if (stat_rd || (mod_tick && cnt_ff == target - CW'(2))) begin
						data_ready_n_ff <= 1'b1;
					end
				end
				default: begin
					data_ready_n_ff <= 1'b1;
				end
			endcase
		end
	end
	assign data_ready_n = data_ready_n_ff;

	// analog power controls
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ref_ff <= 1'b1;
			osc_en_ff <= 1'b0;
			chan_ff <= 4'h0;
		end else begin
			ref_ff <= state_ff != ST_STBY;
			osc_en_ff <= osc_sel_ff && state_ff != ST_STBY;
			chan_ff <= state_ff == ST_CONV ? 4'hf : 4'h0;
		end
	end
	assign ref_enable = ref_ff;
	assign osc_enable = osc_en_ff;
	assign chan_enable = chan_ff;

	//------------------------------------------------------------------
	// checks
	//------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	property p_wait_len;
		wait_done |=> state_ff == ST_CONV && cnt_ff == '0;
	endproperty
	a_wait_len: assert property (p_wait_len) else $error("wait did not end");

	property p_fast_start;
		state_ff == ST_WAIT ##1 state_ff == ST_CONV |-> fast_filter_sel && filter_reset;
	endproperty
	a_fast_start: assert property (p_fast_start) else $error("no fast path");

	property p_sinc_after;
		result_evt && fast_left_ff == 2'h1 |=> !fast_filter_sel ##1 !fast_filter_sel;
	endproperty
	a_sinc_after: assert property (p_sinc_after) else $error("sinc3 late");

	property p_por_end;
		state_ff == ST_POR ##1 state_ff == ST_WAIT |-> data_ready_n && $rose(data_ready_n);
	endproperty
	a_por_end: assert property (p_por_end) else $error("no ready rise");

	property p_defaults;
		soft_rst |=> !osc_sel_ff && osr_sel_ff == OSR_RST && !chop_enable_ff;
	endproperty
	a_defaults: assert property (p_defaults) else $error("no defaults");

	property p_data_ready_n_fall;
		result_evt |=> !data_ready_n && cnt_ff == '0;
	endproperty
	a_data_ready_n_fall: assert property (p_data_ready_n_fall) else $error("no ready fall");

	property p_swap;
		swap_evt && !soft_rst |=> input_swap != $past(input_swap) && filter_reset;
	endproperty
	a_swap: assert property (p_swap) else $error("swap wrong");

	property p_gc_first;
		restart_gc |=> first_ff && cnt_ff == '0 && !input_swap;
	endproperty
	a_gc_first: assert property (p_gc_first) else $error("restart wrong");

	property p_sync;
		sync_mis |=> cnt_ff == '0 && filter_reset;
	endproperty
	a_sync: assert property (p_sync) else $error("sync ignored");

	property p_stby;
		state_ff == ST_STBY ##1 state_ff == ST_STBY |-> !ref_enable && chan_enable == 4'h0;
	endproperty
	a_stby: assert property (p_stby) else $error("standby powered");

	property p_pin_rst;
		ifc.pin_reset |=> state_ff == ST_HOLD;
	endproperty
	a_pin_rst: assert property (p_pin_rst) else $error("pin reset ignored");
endmodule : adcs_seq_top

// File: adcs_host_model.sv
// host controller model: main clock pin and sync/reset pulses
`timescale 1ns/1ps
module adcs_host_model (
	input wire logic clock,
	input wire logic clk_run,
	input wire logic sync_go,
	input wire logic [7:0] sync_len,
	output logic ext_clock_in,
	output logic sync_reset_n
);
	logic [7:0] low_left_ff;
	initial begin
		ext_clock_in = 1'b0;
		sync_reset_n = 1'b1;
		low_left_ff = 8'h00;
	end
	// ------------------------------------------------------------
	// main clock, 40 ns period
	// ------------------------------------------------------------
	// stands still low when stopped so standby draws no clock power
	always #20 begin
		if (clk_run) ext_clock_in = ~ext_clock_in;
		else ext_clock_in = 1'b0;
	end
	// ------------------------------------------------------------
	// sync/reset pin
	// ------------------------------------------------------------
	// low for sync_len clocks; a length beyond the reset threshold acts as a pin reset
	always @(posedge clock) begin
		if (sync_go) begin
			sync_reset_n <= 1'b0;
			low_left_ff <= sync_len;
		end else if (low_left_ff > 8'h01) begin
			low_left_ff <= low_left_ff - 8'h01;
		end else begin
			sync_reset_n <= 1'b1;
		end
	end
endmodule : adcs_host_model

// File: tb_adc_conversion_sequencer.sv
// self-checking bench of the conversion sequencer over its register bus
`timescale 1ns/1ps
module tb_adc_conversion_sequencer
	import adcs_pkg::*;
;
	`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
		$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
	logic clock = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, clk_run = 1'b1, sync_go = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0, power_mode_sel;
	logic [2:0] hsize = 3'h2;
	logic [7:0] sync_len = 8'h14;
	logic hreadyout, hresp, data_ready_n, ref_enable, osc_enable, input_swap, filter_reset;
	logic fast_filter_sel, ext_clock_in, sync_reset_n, sw_a;
	logic [3:0] chan_enable;
	logic [1:0] pm [3] = '{high_resolution_power, reduced_power_level, minimum_power_level};
	int error_cnt = 0, checks_done = 0, cyc = 0, fr_cnt = 0, n, t;
	localparam logic [31:0] A_CFG = {24'h0, OFS_CONFIG};
	localparam logic [31:0] A_CMD = {24'h0, OFS_CMD};
	localparam logic [31:0] A_STS = {24'h0, OFS_STATUS};

	always #5 clock = ~clock;
	// non-blocking so that the main sequence always reads the value before the edge
	always @(posedge clock) begin
		cyc <= cyc + 1;
		fr_cnt <= fr_cnt + int'(filter_reset === 1'b1);
		if (cyc == 90000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	adcs_seq_top i_dut (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_clock_in(ext_clock_in),
		.sync_reset_n(sync_reset_n), .data_ready_n(data_ready_n), .chan_enable(chan_enable),
		.ref_enable(ref_enable), .osc_enable(osc_enable), .input_swap(input_swap),
		.filter_reset(filter_reset), .fast_filter_sel(fast_filter_sel),
		.power_mode_sel(power_mode_sel));
	adcs_host_model i_host (.clock(clock), .clk_run(clk_run), .sync_go(sync_go),
		.sync_len(sync_len), .ext_clock_in(ext_clock_in), .sync_reset_n(sync_reset_n));

	// ------------------------------------------------------------
	// bus and pin tasks, entered just after a rising edge
	// ------------------------------------------------------------
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		rd = hrdata;
	endtask : ahb
	task automatic wait_fall(output int c);
		logic p;
		c = 0;
		forever begin
			p = data_ready_n;
			@(posedge clock);
			c++;
			if (p === 1'b1 && data_ready_n === 1'b0) break;
		end
	endtask : wait_fall
	task automatic sync_pulse(input logic [7:0] len);
		sync_len <= len;
		sync_go <= 1'b1;
		@(posedge clock);
		sync_go <= 1'b0;
	endtask : sync_pulse
	task automatic report_and_stop();
		$display("TB: %0d checks, %0d errors", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clock);
		`CHK(osc_enable, 1'b0)
		rstn <= 1'b1;
		repeat (1990) @(posedge clock);
		`CHK(data_ready_n, 1'b0)
		repeat (20) @(posedge clock);
		`CHK(data_ready_n, 1'b1)
		ahb(1'b0, A_CFG, 32'h0);
		`CHK(rd, 32'h00000300)
		`CHK(hresp, 1'b0)
		ahb(1'b0, 32'h0000000c, 32'h0);
		`CHK(rd, 32'h00000000)
		foreach (pm[i]) begin
			ahb(1'b1, A_CFG, {24'h0, pm[i], 6'h0});
			repeat (2) @(posedge clock);
			`CHK(power_mode_sel, pm[i])
		end
		// standby with the oscillator chosen; main clock stopped meanwhile
		ahb(1'b1, A_CFG, 32'h00000301);
		repeat (3) @(posedge clock);
		`CHK(osc_enable, 1'b1)
		ahb(1'b1, A_CMD, 32'h2);
		clk_run <= 1'b0;
		repeat (3) @(posedge clock);
		`CHK({chan_enable, ref_enable, osc_enable}, 6'h00)
		ahb(1'b0, A_STS, 32'h0);
		`CHK(rd[S_STBY], 1'b1)
		ahb(1'b0, A_CFG, 32'h0);
		`CHK(rd, 32'h00000301)
		ahb(1'b1, A_CMD, 32'h4);
		clk_run <= 1'b1;
		repeat (3) @(posedge clock);
		ahb(1'b0, A_STS, 32'h0);
		`CHK({rd[S_STBY], ref_enable}, 2'b01)
		// command reset at the default ratio of 1024: 1324 then one 1024 period
		ahb(1'b1, A_CMD, 32'h1);
		repeat (3) @(posedge clock);
		`CHK({osc_enable, fast_filter_sel}, 2'b01)
		ahb(1'b0, A_CFG, 32'h0);
		`CHK(rd, 32'h00000300)
		wait_fall(t);
		`CHK(t >= 10560 && t <= 10624, 1'b1)
		repeat (2) @(posedge clock);
		`CHK(fast_filter_sel, 1'b1)
		wait_fall(t);
		// two edges went to the fast path check before counting resumed
		`CHK(t + 2, 8192)
		repeat (2) @(posedge clock);
		`CHK(fast_filter_sel, 1'b0)
		ahb(1'b0, A_STS, 32'h0);
		@(posedge clock);
		`CHK(data_ready_n, 1'b1)
		// continuous at ratio 128, then a misaligned sync
		ahb(1'b1, A_CFG, 32'h0);
		wait_fall(t);
		wait_fall(t);
		`CHK(t, 1024)
		repeat (300) @(posedge clock);
		n = fr_cnt;
		sync_pulse(8'h14);
		wait_fall(t);
		`CHK(fr_cnt - n, 1)
		`CHK(t >= 1010 && t <= 1040, 1'b1)
		// chop: restart by sync, then steady periods of 2 + 384 ticks
		ahb(1'b1, A_CFG, 32'h2);
		sync_pulse(8'h14);
		wait_fall(t);
		`CHK(t >= 6500 && t <= 6560, 1'b1)
		repeat (1500) @(posedge clock);
		sw_a = input_swap;
		n = fr_cnt;
		wait_fall(t);
		repeat (1500) @(posedge clock);
		`CHK(input_swap, ~sw_a)
		`CHK(fr_cnt - n, 1)
		wait_fall(t);
		`CHK(t, 1588)
		ahb(1'b1, A_CFG, 32'h0000000e);
		wait_fall(t);
		wait_fall(t);
		`CHK(t, 3200)
		// a new ratio in chop mode restarts: 2 * (16 + 768) + 44 ticks
		ahb(1'b1, A_CFG, 32'h0000010e);
		wait_fall(t);
		`CHK(t >= 12880 && t <= 12905, 1'b1)
		// long low level on the pin resets the configuration
		ahb(1'b1, A_CFG, 32'h1);
		sync_pulse(8'h96);
		repeat (170) @(posedge clock);
		ahb(1'b0, A_CFG, 32'h0);
		`CHK(rd, 32'h00000300)
		`CHK({osc_enable, fast_filter_sel}, 2'b01)
		report_and_stop();
	end
endmodule : tb_adc_conversion_sequencer
